/* collision_retry_ctr.sv */
`timescale 1ns/100ps
module collision_retry_ctr
  import fwd_policy_pkg::*;
#(
  parameter int Limit = MaxCollisions
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic txStart,
  input wire logic txDone,
  input wire logic collision,
  input wire logic keepOnExcess,
  output logic retry_q,
  output logic discard_q,
  output logic stuck_q
);
  tx_state_t state_q, state_d;
  logic [CollCountW-1:0] count_q, count_d;
  logic retry_d;
  logic discard_d;
  logic reachLimit;

  always_comb
  begin
    state_d = state_q;
    count_d = count_q;
    retry_d = 1'b0;
    discard_d = 1'b0;
    reachLimit = (count_q >= CollCountW'(Limit - 1));
    case (state_q)
      TxIdle:
      begin
        count_d = '0;
        if (txStart)
        begin
          state_d = TxActive;
        end
      end
      TxActive, TxStuck:
      begin
        if (txDone)
        begin
          state_d = TxIdle;
        end
        else if (collision)
        begin
          if (!reachLimit)
          begin
            count_d = CollCountW'(count_q + 1'b1);
            retry_d = 1'b1;
          end
          // RULE9 keep retrying
          else if (keepOnExcess)
          begin
            count_d = CollCountW'(Limit);
            retry_d = 1'b1;
            state_d = TxStuck;
          end
          // RULE10 discard at limit
          else
          begin
            discard_d = 1'b1;
            state_d = TxIdle;
          end
        end
      end
      default:
      begin
        state_d = TxIdle;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_q <= TxIdle;
      count_q <= '0;
      retry_q <= 1'b0;
      discard_q <= 1'b0;
      stuck_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      count_q <= count_d;
      retry_q <= retry_d;
      discard_q <= discard_d;
      stuck_q <= (state_d == TxStuck);
    end
  end
endmodule : collision_retry_ctr

/* frame_policy_check.sv */
`timescale 1ns/100ps
module frame_policy_check
  import fwd_policy_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire policy_t policy,
  input wire frame_req_t req,
  output frame_verdict_t verdict_q
);
  frame_verdict_t verdict_d;
  logic isBcast;
  logic isGroup;
  logic crossing;
  logic mirrorCross;

  always_comb
  begin
    isBcast = (req.destAddr == BcastAddr);
    isGroup = req.destAddr[GroupBit];
    crossing = !req.egressInVlan;
    mirrorCross = req.mirrorOn && !req.mirrorInVlan;
    verdict_d = '0;
    verdict_d.valid = req.valid;
    // RULE1 RULE2 crossing check
    verdict_d.vlanDrop = crossing && (policy.vlanDiscard || !(req.knownUnicast && !isGroup));
    // RULE3 mirrored crossing drop
    if (policy.vlanDiscard && req.singleDest && mirrorCross)
    begin
      verdict_d.vlanDrop = 1'b1;
    end
    verdict_d.forward = req.valid && !verdict_d.vlanDrop;
    verdict_d.mirror = verdict_d.forward && req.mirrorOn;
    // RULE4 RULE5 storm class
    verdict_d.stormRegulated = req.valid && (isBcast || (!policy.mcastExcl && isGroup));
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      verdict_q <= '0;
    end
    else
    begin
      verdict_q <= verdict_d;
    end
  end
endmodule : frame_policy_check

/* fwd_policy_checker.sv */
`timescale 1ns/100ps
module fwd_policy_checker
  import fwd_policy_pkg::*;
#(
  parameter int Ports = NumPorts
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [DataW-1:0] hrdata,
  input wire frame_req_t frameReq,
  input wire frame_verdict_t frameVerdict,
  input wire logic [Ports-1:0] forceCollision,
  input wire logic [Ports-1:0] fairDrop,
  input wire logic [Ports-1:0] txDiscard,
  input wire policy_t policy
);
  logic rdPol_q;
  logic rdPol_d;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // policy reads are judged in their data phase only
  always_comb rdPol_d = hsel && htrans[1] && !hwrite && haddr == PolicyAddr;
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b) rdPol_q <= 1'b0;
    else if (hready) rdPol_q <= rdPol_d;
  ready_a: assert property (hreadyout && !hresp)
    else $error("bus answer not zero-wait okay");
  vlan_block_a: assert property (
    $past(frameReq.valid && !frameReq.egressInVlan && policy.vlanDiscard) && policy.vlanDiscard
    |-> !frameVerdict.forward) else $error("frame left its vlan");
  vlan_cross_a: assert property (
    $past(frameReq.valid && !frameReq.egressInVlan && !policy.vlanDiscard
    && (!frameReq.knownUnicast || frameReq.destAddr[GroupBit])) && !policy.vlanDiscard
    |-> !frameVerdict.forward) else $error("non unicast crossed vlan");
  mirror_drop_a: assert property (
    $past(frameReq.valid && frameReq.mirrorOn && frameReq.singleDest && !frameReq.mirrorInVlan
    && policy.vlanDiscard) && policy.vlanDiscard
    |-> !frameVerdict.forward && !frameVerdict.mirror) else $error("mirrored frame kept");
  bcast_storm_a: assert property (
    $past(frameReq.valid && frameReq.destAddr == BcastAddr)
    |-> frameVerdict.valid && frameVerdict.stormRegulated) else $error("broadcast not regulated");
  mcast_excl_a: assert property (
    $past(frameReq.valid && frameReq.destAddr != BcastAddr && policy.mcastExcl) && policy.mcastExcl
    |-> !frameVerdict.stormRegulated) else $error("multicast regulated");
  mcast_incl_a: assert property (
    $past(frameReq.valid && frameReq.destAddr[GroupBit] && !policy.mcastExcl) && !policy.mcastExcl
    |-> frameVerdict.stormRegulated) else $error("multicast not regulated");
  force_coll_a: assert property (forceCollision != '0 |-> !policy.bpMode)
    else $error("collision forced in other mode");
  fair_drop_a: assert property (fairDrop != '0 |-> policy.fair)
    else $error("fair drop without fair mode");
  keep_frame_a: assert property (
    txDiscard != '0 |-> !policy.collKeep)
    else $error("discard while keep set");
  reserved_rd_a: assert property (rdPol_q |-> hrdata[2:0] == 3'h0 && hrdata[31:8] == 24'h0)
    else $error("reserved policy bits not zero");
  reset_val_a: assert property ($rose(rst_b) |-> policy == PolicyResetVal[7:3])
    else $error("policy reset value wrong");
endmodule : fwd_policy_checker

/* fwd_policy_pkg.sv */
package fwd_policy_pkg;
  // Notes on behaviour
  // RULE1: discard bit set: never forward a frame outside the ingress VLAN membership.
  // RULE2: discard bit clear: only known unicast crosses VLANs; others stay confined.
  // RULE3: mirroring on: single-destination frame mirrored across the VLAN boundary is dropped; the code drops it only while the discard bit is set.
  // RULE4: multicast exclusion bit 6 set: storm protection regulates only all-ones DA.
  // RULE5: exclusion bit clear: storm protection regulates all-ones DA and DA bit 40 set.
  // RULE6: back-pressure mode bit 5 clear: force collisions on the congested half-duplex port.
  // RULE7: fair bit 4 set: drop non-flow-controlled source instead of pausing flow-controlled one.
  // RULE8: fair bit clear: contending flow-controlled port gets flow control applied.
  // RULE9: keep bit 3 set: half-duplex port keeps retrying after 16 or more collisions.
  // RULE10: keep bit clear: frame discarded once it has suffered 16 collisions.
  // RULE11: bit 2 reserved: reads 0, writes ignored; software leaves it unchanged.
  // RULE12: after reset bits 7..4 read 1 and bit 3 reads 0.

  localparam int NumPorts = 5;
  localparam int DataW = 32;

  localparam logic [31:0] PolicyAddr = 32'h0000_0000;
  localparam logic [31:0] DropCountAddr = 32'h0000_0004;
  localparam logic [31:0] CollCountAddr = 32'h0000_0008;
  localparam logic [11:0] AddrDecodeMask = 12'hFFC;

  localparam int VlanDiscardBit = 7;
  localparam int McastExclBit = 6;
  localparam int BpModeBit = 5;
  localparam int FairBit = 4;
  localparam int CollKeepBit = 3;
  localparam int ReservedBit = 2;
  localparam logic [7:0] PolicyResetVal = 8'hF0;
  localparam logic [7:0] PolicyWriteMask = 8'hF8;

  localparam int MaxCollisions = 16;
  localparam int CollCountW = 5;
  localparam logic [47:0] BcastAddr = 48'hFFFF_FFFF_FFFF;
  localparam int GroupBit = 40;
  localparam int StatCountW = 8;

  localparam logic [1:0] HtransNonseq = 2'h2;
  localparam logic [2:0] HsizeWord = 3'h2;

  typedef struct packed {
    logic vlanDiscard;
    logic mcastExcl;
    logic bpMode;
    logic fair;
    logic collKeep;
  } policy_t;

  typedef struct packed {
    logic valid;
    logic [47:0] destAddr;
    logic knownUnicast;
    logic egressInVlan;
    logic mirrorOn;
    logic singleDest;
    logic mirrorInVlan;
  } frame_req_t;

  typedef struct packed {
    logic valid;
    logic forward;
    logic mirror;
    logic vlanDrop;
    logic stormRegulated;
  } frame_verdict_t;

  typedef enum logic [2:0] {
    StIdle = 3'b001,
    StWrite = 3'b010,
    StRead = 3'b100
  } bus_state_t;

  typedef enum logic [2:0] {
    TxIdle = 3'b001,
    TxActive = 3'b010,
    TxStuck = 3'b100
  } tx_state_t;
endpackage : fwd_policy_pkg

/* host_cpu_model.sv */
`timescale 1ns/100ps
module host_cpu_model
  import fwd_policy_pkg::*;
(
  input wire logic clk,
  input wire logic hready,
  input wire logic [DataW-1:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [DataW-1:0] hwdata
);
  int tmo = 0;
  initial
  begin
    {hsel, haddr, htrans, hwrite, hwdata} = '0;
    hsize = HsizeWord;
  end
  task automatic waitReady();
    int n;
    n = 0;
    @(posedge clk);
    while (hready !== 1'b1 && n < 64)
    begin
      @(posedge clk);
      n++;
    end
    if (n == 64) tmo++;
  endtask : waitReady
  // call at a rising edge; gap idles first to act as a slow host
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d, input int gap,
                      output logic [31:0] r);
    repeat (gap) @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= HtransNonseq;
    waitReady();
    hsel <= 1'b0;
    htrans <= 2'h0;
    haddr <= ~a;
    hwdata <= w ? d & ~32'h4 : ~hwdata;
    waitReady();
    r = hrdata;
  endtask : xfer
endmodule : host_cpu_model

/* switch_forwarding_policy_ctrl.sv */
// Decided for this implementation: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/100ps
module switch_forwarding_policy_ctrl
  import fwd_policy_pkg::*;
#(
  parameter int Ports = NumPorts,
  parameter int CollLimit = MaxCollisions
)
(
  input wire logic clk,
  input wire logic rst_b,
  // register bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [2:0] hburst,
  input wire logic [3:0] hprot,
  input wire logic [DataW-1:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [DataW-1:0] hrdata,
  // per-frame forwarding check
  input wire frame_req_t frameReq,
  output frame_verdict_t frameVerdict,
  // congestion handling, one bit per port except wantDest, which holds one destination mask per source port
  input wire logic [Ports-1:0][Ports-1:0] wantDest,
  input wire logic [Ports-1:0] destCongested,
  input wire logic [Ports-1:0] halfDuplex,
  input wire logic [Ports-1:0] flowCtlEn,
  output logic [Ports-1:0] forceCollision,
  output logic [Ports-1:0] carrierHold,
  output logic [Ports-1:0] pauseReq,
  output logic [Ports-1:0] fairDrop,
  // half-duplex transmit retry handling
  input wire logic [Ports-1:0] txStart,
  input wire logic [Ports-1:0] txDone,
  input wire logic [Ports-1:0] txCollision,
  output logic [Ports-1:0] txRetry,
  output logic [Ports-1:0] txDiscard,
  output logic [Ports-1:0] txStuck,
  // current policy for the forwarding engine
  output policy_t policy
);
  bus_state_t busState_q, busState_d;
  logic [11:0] phaseAddr_q, phaseAddr_d;
  logic [DataW-1:0] rdata_q, rdata_d;
  logic [7:0] policyBits_q, policyBits_d;
  logic accept;
  logic [11:0] addrWord;
  logic [DataW-1:0] readMux;
  logic [7:0] bypassBits;

  logic [StatCountW-1:0] vlanDropCnt_q, vlanDropCnt_d;
  logic [StatCountW-1:0] stormCnt_q, stormCnt_d;
  logic [StatCountW-1:0] fairDropCnt_q, fairDropCnt_d;
  logic [StatCountW-1:0] excessCnt_q, excessCnt_d;
  logic [StatCountW-1:0] stuckCnt_q, stuckCnt_d;

  logic [Ports-1:0] fcTargets, nonFcTargets, contend;
  logic [Ports-1:0] forceCollision_d, carrierHold_d, pauseReq_d, fairDrop_d;
  logic [Ports-1:0] congestedTarget, hitsContend;

  policy_t policyNow;

  // hburst and hprot carry nothing for single word registers
  logic unusedBusBits;
  assign unusedBusBits = ^{hburst, hprot, hsize};

  function automatic logic [StatCountW-1:0] satInc(input logic [StatCountW-1:0] v,
                                                   input logic hit);
    logic [StatCountW-1:0] r;
    r = v;
    if (hit && (v != {StatCountW{1'b1}}))
    begin
      r = StatCountW'(v + 1'b1);
    end
    return r;
  endfunction : satInc

  assign policyNow.vlanDiscard = policyBits_q[VlanDiscardBit];
  assign policyNow.mcastExcl = policyBits_q[McastExclBit];
  assign policyNow.bpMode = policyBits_q[BpModeBit];
  assign policyNow.fair = policyBits_q[FairBit];
  assign policyNow.collKeep = policyBits_q[CollKeepBit];

  // bus slave: zero wait states, always OKAY
  always_comb
  begin
    accept = hsel && hready && (htrans == HtransNonseq || htrans == 2'h3);
    addrWord = haddr[11:0] & AddrDecodeMask;
    busState_d = StIdle;
    phaseAddr_d = phaseAddr_q;
    if (accept)
    begin
      // high addresses park on an unused word so writes there fall away
      phaseAddr_d = (haddr[31:12] == 20'h0_0000) ? addrWord : AddrDecodeMask;
      busState_d = hwrite ? StWrite : StRead;
    end
  end

  // a read right behind a write to the policy register sees the new bits
  always_comb
  begin
    bypassBits = policyBits_q;
    if (busState_q == StWrite && phaseAddr_q == PolicyAddr[11:0])
    begin
      bypassBits = (hwdata[7:0] & PolicyWriteMask) | (policyBits_q & ~PolicyWriteMask);
    end
    readMux = '0;
    if (haddr[31:12] == 20'h0_0000)
    begin
      case (addrWord)
        // RULE11 reserved reads zero
        PolicyAddr[11:0]: readMux = {24'h00_0000, bypassBits & PolicyWriteMask};
        DropCountAddr[11:0]: readMux = {fairDropCnt_q, stormCnt_q, vlanDropCnt_q, 8'h00};
        CollCountAddr[11:0]: readMux = {16'h0000, stuckCnt_q, excessCnt_q};
        default: readMux = '0;
      endcase
    end
    rdata_d = rdata_q;
    if (accept && !hwrite)
    begin
      rdata_d = readMux;
    end
  end

  always_comb
  begin
    policyBits_d = policyBits_q;
    if (busState_q == StWrite && phaseAddr_q == PolicyAddr[11:0])
    begin
      // RULE11 reserved write ignored
      policyBits_d = (hwdata[7:0] & PolicyWriteMask) | (policyBits_q & ~PolicyWriteMask);
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      busState_q <= StIdle;
      phaseAddr_q <= '0;
      rdata_q <= '0;
      // RULE12 reset values
      policyBits_q <= PolicyResetVal;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      busState_q <= busState_d;
      phaseAddr_q <= phaseAddr_d;
      rdata_q <= rdata_d;
      policyBits_q <= policyBits_d;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  assign hrdata = rdata_q;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      policy <= '0;
      policy.vlanDiscard <= PolicyResetVal[VlanDiscardBit];
      policy.mcastExcl <= PolicyResetVal[McastExclBit];
      policy.bpMode <= PolicyResetVal[BpModeBit];
      policy.fair <= PolicyResetVal[FairBit];
      policy.collKeep <= PolicyResetVal[CollKeepBit];
    end
    else
    begin
      policy <= policyNow;
    end
  end

  frame_policy_check u_check (
    .clk(clk),
    .rst_b(rst_b),
    .policy(policyNow),
    .req(frameReq),
    .verdict_q(frameVerdict)
  );

  // contention: a congested destination wanted by both kinds of source
  always_comb
  begin
    fcTargets = '0;
    nonFcTargets = '0;
    for (int i = 0; i < Ports; i++)
    begin
      if (flowCtlEn[i])
      begin
        fcTargets = fcTargets | wantDest[i];
      end
      else
      begin
        nonFcTargets = nonFcTargets | wantDest[i];
      end
    end
    contend = fcTargets & nonFcTargets & destCongested;
  end

  always_comb
  begin
    for (int i = 0; i < Ports; i++)
    begin
      congestedTarget[i] = |(wantDest[i] & destCongested);
      hitsContend[i] = |(wantDest[i] & contend);
      // RULE6 collision back pressure
      forceCollision_d[i] = halfDuplex[i] && congestedTarget[i] && !policyNow.bpMode;
      carrierHold_d[i] = halfDuplex[i] && congestedTarget[i] && policyNow.bpMode;
      // RULE7 RULE8 fair arbitration
      pauseReq_d[i] = flowCtlEn[i] && !halfDuplex[i] && congestedTarget[i]
                      && !(policyNow.fair && hitsContend[i]);
      fairDrop_d[i] = !flowCtlEn[i] && policyNow.fair && hitsContend[i];
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      forceCollision <= '0;
      carrierHold <= '0;
      pauseReq <= '0;
      fairDrop <= '0;
    end
    else
    begin
      forceCollision <= forceCollision_d;
      carrierHold <= carrierHold_d;
      pauseReq <= pauseReq_d;
      fairDrop <= fairDrop_d;
    end
  end

  // one retry counter per port; only half-duplex ports pass collisions to it
  for (genvar p = 0; p < Ports; p++)
  begin : g_port
    collision_retry_ctr #(
      .Limit(CollLimit)
    ) u_retry (
      .clk(clk),
      .rst_b(rst_b),
      .txStart(txStart[p]),
      .txDone(txDone[p]),
      .collision(txCollision[p] && halfDuplex[p]),
      .keepOnExcess(policyNow.collKeep),
      .retry_q(txRetry[p]),
      .discard_q(txDiscard[p]),
      .stuck_q(txStuck[p])
    );
  end

  // statistics saturate rather than wrap so a long run stays readable
  always_comb
  begin
    vlanDropCnt_d = satInc(vlanDropCnt_q, frameVerdict.valid && frameVerdict.vlanDrop);
    stormCnt_d = satInc(stormCnt_q, frameVerdict.valid && frameVerdict.stormRegulated);
    fairDropCnt_d = satInc(fairDropCnt_q, |fairDrop);
    excessCnt_d = satInc(excessCnt_q, |txDiscard);
    stuckCnt_d = satInc(stuckCnt_q, |(txRetry & txStuck));
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      vlanDropCnt_q <= '0;
      stormCnt_q <= '0;
      fairDropCnt_q <= '0;
      excessCnt_q <= '0;
      stuckCnt_q <= '0;
    end
    else
    begin
      vlanDropCnt_q <= vlanDropCnt_d;
      stormCnt_q <= stormCnt_d;
      fairDropCnt_q <= fairDropCnt_d;
      excessCnt_q <= excessCnt_d;
      stuckCnt_q <= stuckCnt_d;
    end
  end
endmodule : switch_forwarding_policy_ctrl

/* switch_forwarding_policy_ctrl_tb.sv */
`timescale 1ns/100ps
`define CHK(nm, e, g) \
  begin \
    nChecks++; \
    if ((g) !== (e)) \
    begin \
      miscompares++; \
      $display("MISMATCH %s exp %0h got %0h", nm, e, g); \
    end \
  end
module switch_forwarding_policy_ctrl_tb
  import fwd_policy_pkg::*;
;
  localparam int Lim = 4;
  logic clk, rst_b, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rdv;
  logic [1:0] htrans;
  logic [2:0] hsize;
  frame_req_t frameReq;
  frame_verdict_t frameVerdict;
  policy_t policy;
  logic [NumPorts-1:0][NumPorts-1:0] wantDest;
  logic [NumPorts-1:0] destCongested, halfDuplex, flowCtlEn, forceCollision, carrierHold;
  logic [NumPorts-1:0] pauseReq, fairDrop, txStart, txDone, txCollision, txRetry, txDiscard;
  logic [NumPorts-1:0] txStuck;
  logic [7:0] lf = 8'h1C;
  logic [7:0] pols [4] = '{8'h8F, 8'h7B, 8'hC4, 8'h38};
  int miscompares = 0;
  int nChecks = 0;
  int nVlan = 0;
  int nStorm = 0;

  switch_forwarding_policy_ctrl #(.CollLimit(Lim)) DUT (.clk, .rst_b, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hburst(3'h0), .hprot(4'h3), .hwdata, .hready(hreadyout), .hreadyout,
    .hresp, .hrdata, .frameReq, .frameVerdict, .wantDest, .destCongested, .halfDuplex,
    .flowCtlEn, .forceCollision, .carrierHold, .pauseReq, .fairDrop, .txStart, .txDone,
    .txCollision, .txRetry, .txDiscard, .txStuck, .policy);
  host_cpu_model host (.clk, .hready(hreadyout), .hrdata, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata);

  function automatic logic [7:0] step(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : step
  // reference verdict: {forward, stormRegulated}
  function automatic logic [1:0] expV(input logic [7:0] p, input frame_req_t f);
    logic grp, fw;
    grp = f.destAddr[GroupBit];
    fw = f.egressInVlan || (!p[VlanDiscardBit] && f.knownUnicast && !grp);
    if (p[VlanDiscardBit] && f.mirrorOn && f.singleDest && !f.mirrorInVlan) fw = 1'b0;
    return {fw, f.destAddr == BcastAddr || (!p[McastExclBit] && grp)};
  endfunction : expV
  // reference congestion outputs: {forceCollision, carrierHold, pauseReq, fairDrop}
  function automatic logic [19:0] expC(input logic [7:0] p);
    logic [NumPorts-1:0] fcT, nfT, fc, ch, pr, fd;
    logic cg, hit;
    fcT = '0;
    nfT = '0;
    for (int i = 0; i < NumPorts; i++)
    begin
      if (flowCtlEn[i]) fcT = fcT | wantDest[i];
      else nfT = nfT | wantDest[i];
    end
    for (int i = 0; i < NumPorts; i++)
    begin
      cg = |(wantDest[i] & destCongested);
      hit = |(wantDest[i] & fcT & nfT & destCongested);
      fc[i] = halfDuplex[i] && cg && !p[BpModeBit];
      ch[i] = halfDuplex[i] && cg && p[BpModeBit];
      pr[i] = flowCtlEn[i] && !halfDuplex[i] && cg && !(p[FairBit] && hit);
      fd[i] = !flowCtlEn[i] && p[FairBit] && hit;
    end
    return {fc, ch, pr, fd};
  endfunction : expC
  task automatic testDone();
    if (miscompares == 0 && nChecks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : testDone
  task automatic rd(input logic [31:0] a, input logic [31:0] e, input int gap);
    logic [31:0] r;
    host.xfer(1'b0, a, 32'h0, gap, r);
    `CHK("hrdata", e, r)
  endtask : rd
  task automatic frame(input logic [7:0] p);
    frame_req_t f;
    logic [1:0] e;
    logic [19:0] c;
    lf = step(lf);
    f = '0;
    f.valid = 1'b1;
    f.destAddr = lf[1] ? BcastAddr : {7'h0, lf[0], 32'h0, lf};
    {f.knownUnicast, f.egressInVlan, f.mirrorOn, f.singleDest, f.mirrorInVlan} = lf[7:3];
    e = expV(p, f);
    @(posedge clk);
    frameReq <= f;
    {halfDuplex, flowCtlEn} <= {lf, lf[7:6]};
    destCongested <= lf[4:0];
    wantDest <= {lf, lf, lf, lf[0]};
    @(posedge clk);
    frameReq.valid <= 1'b0;
    #1;
    `CHK("forward", e[1], frameVerdict.forward)
    `CHK("storm", e[0], frameVerdict.stormRegulated)
    `CHK("mirror", e[1] && f.mirrorOn, frameVerdict.mirror)
    `CHK("vlanDrop", !e[1], frameVerdict.vlanDrop)
    c = expC(p);
    `CHK("forceCollision", c[19:15], forceCollision)
    `CHK("carrierHold", c[14:10], carrierHold)
    `CHK("pauseReq", c[9:5], pauseReq)
    `CHK("fairDrop", c[4:0], fairDrop)
    nVlan += !e[1];
    nStorm += e[0];
  endtask : frame
  task automatic retry(input int p, input logic keep);
    @(posedge clk);
    halfDuplex <= '1;
    txStart[p] <= 1'b1;
    @(posedge clk);
    txStart[p] <= 1'b0;
    for (int c = 1; c <= Lim; c++)
    begin
      @(posedge clk);
      txCollision[p] <= 1'b1;
      @(posedge clk);
      txCollision[p] <= 1'b0;
      #1;
      `CHK("retry", c < Lim || keep, txRetry[p])
      `CHK("discard", c == Lim && !keep, txDiscard[p])
    end
    `CHK("stuck", keep, txStuck[p])
    @(posedge clk);
    txDone[p] <= 1'b1;
    @(posedge clk);
    txDone[p] <= 1'b0;
  endtask : retry

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    repeat (50000) @(posedge clk);
    miscompares++;
    testDone();
  end
  initial
  begin
    rst_b = 1'b0;
    {frameReq, wantDest, destCongested, halfDuplex, flowCtlEn, txStart, txDone, txCollision} = '0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    #1;
    `CHK("policy", PolicyResetVal[7:3], policy)
    @(posedge clk);
    rd(PolicyAddr, {24'h0, PolicyResetVal}, 0);
    rd(32'h0000_0010, 32'h0, 1);
    for (int k = 0; k < 4; k++)
    begin
      host.xfer(1'b1, PolicyAddr, {24'h0, pols[k]}, k, rdv);
      rd(PolicyAddr, {24'h0, pols[k] & PolicyWriteMask}, 0);
      repeat (2) @(posedge clk);
      #1;
      `CHK("policy", pols[k][7:3], policy)
      repeat (8) frame(pols[k]);
      retry(k, pols[k][CollKeepBit]);
      @(posedge clk);
    end
    rd(CollCountAddr, 32'h0000_0301, 0);
    host.xfer(1'b0, DropCountAddr, 32'h0, 0, rdv);
    `CHK("drops", {nStorm[7:0], nVlan[7:0]}, rdv[23:8])
    `CHK("timeout", 0, host.tmo)
    testDone();
  end
endmodule : switch_forwarding_policy_ctrl_tb

bind switch_forwarding_policy_ctrl fwd_policy_checker #(.Ports(Ports)) chk (.clk, .rst_b,
  .hsel, .haddr, .htrans, .hwrite, .hready, .hreadyout, .hresp, .hrdata, .frameReq,
  .frameVerdict, .forceCollision, .fairDrop, .txDiscard, .policy);
